/* File: deser_params.svh */
`ifndef DESER_PARAMS_SVH
`define DESER_PARAMS_SVH

// Register byte offsets on the APB slave.
`define OFS_CTRL 12'h000
`define OFS_STATE 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C

// Channel count and per-channel field spacing inside CTRL and STATE.
`define NUM_CH 4
`define CH_STRIDE 8

// CTRL field positions within a channel byte.
`define CTRL_RATE_BIT 0
`define CTRL_ST_LO 1
`define CTRL_EN_ONE_BIT 3
`define CTRL_EN_TWO_BIT 4

// STATE field positions within a channel byte.
`define STATE_LOCK_BIT 0
`define STATE_PD_BIT 1
`define STATE_ST_BIT 2

// Interrupt bit groups: lock loss on bits 3:0, self-test flag on bits 7:4.
`define IRQ_LOCK_LO 0
`define IRQ_ST_LO 4

// Reset values: full rate, self-test off, both reclocker outputs enabled.
`define CTRL_RESET 32'h18181818
`define IRQ_MASK_RESET 32'h00000000

// Self-test control code that makes the status outputs valid.
`define ST_REPORT_CODE 2'h2

`endif

/* File: deser_pkg.sv */
package deser_pkg;

  // One recovered character.
  typedef logic [9:0] char_t;

  // Receive clock rate select.
  typedef enum logic {
    FULL_RATE = 1'b0,
    HALF_RATE = 1'b1
  } rate_t;

  // Two-bit receive self-test control.
  typedef logic [1:0] st_ctrl_t;

endpackage

/* File: lane_if.sv */
`timescale 1ns/1ps

// Configuration and results of one receive channel output lane.
interface lane_if;
  deser_pkg::rate_t rate_sel;
  deser_pkg::st_ctrl_t st_ctrl;
  logic en_one;
  logic en_two;
  logic lock;
  deser_pkg::char_t char_in;
  logic [2:0] st_status;
  deser_pkg::char_t par_char;
  logic clk_p;
  logic clk_n;
  logic st_flag;
  logic pd_flag;
  logic reclk;

  // The top drives configuration and recovered data in and reads results.
  modport top (
    output rate_sel, st_ctrl, en_one, en_two, lock, char_in, st_status,
    input par_char, clk_p, clk_n, st_flag, pd_flag, reclk
  );

  // The lane consumes configuration and produces the output pins.
  modport lane (
    input rate_sel, st_ctrl, en_one, en_two, lock, char_in, st_status,
    output par_char, clk_p, clk_n, st_flag, pd_flag, reclk
  );
endinterface

/* File: rx_out_lane.sv */
`timescale 1ns/1ps
`include "deser_params.svh"

module rx_out_lane (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Training reference pin of this channel
  input wire logic training_ref_clock,
  // Channel configuration and outputs
  lane_if.lane lif
);

  logic trg_s1_r;
  logic trg_s2_r;
  logic trg_s3_r;
  logic sub_r;
  logic clk_p_r;
  logic clk_n_r;
  logic reclk_r;
  logic flag_r;
  deser_pkg::char_t data_r;
  logic half_tick;
  logic char_tick;
  logic selftest_on;
  logic powered_down;

  // Training clock is a pin, so it passes two flops before the edge detector reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s1_r <= 1'b0;
      trg_s2_r <= 1'b0;
      trg_s3_r <= 1'b0;
    end else begin
      trg_s1_r <= training_ref_clock;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
    end
  end

  // Locked: timing comes from pclk alone, one half-character step per cycle, with no tie to the training clock.
  // Unlocked: each training clock edge paces the lane, which shortens acquisition.
  assign half_tick = lif.lock ? 1'b1 : (trg_s2_r ^ trg_s3_r);
  assign char_tick = half_tick & sub_r;
  assign selftest_on = (lif.st_ctrl == `ST_REPORT_CODE);
  assign powered_down = ~lif.en_one & ~lif.en_two;

  // Half-character phase and receive clock pair; both flops so the pair never skews.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_r <= 1'b0;
      clk_p_r <= 1'b0;
      clk_n_r <= 1'b1;
    end else if (half_tick) begin
      sub_r <= ~sub_r;
      if (lif.rate_sel == deser_pkg::FULL_RATE) begin
        clk_p_r <= sub_r;
        clk_n_r <= ~sub_r;
      end else if (sub_r) begin
        clk_p_r <= ~clk_p_r;
        clk_n_r <= clk_p_r;
      end
    end
  end

  // Reclocker clock runs at the character rate; it is held low while powered down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reclk_r <= 1'b0;
    end else if (powered_down) begin
      reclk_r <= 1'b0;
    end else if (half_tick) begin
      reclk_r <= ~reclk_r;
    end
  end

  // Character register: the low two bits carry self-test status when reporting is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 10'h000;
      flag_r <= 1'b0;
    end else if (char_tick) begin
      if (selftest_on) begin
        data_r <= {lif.char_in[9:2], lif.st_status[1:0]};
        flag_r <= lif.st_status[2];
      end else begin
        data_r <= lif.char_in;
        flag_r <= 1'b0;
      end
    end
  end

  assign lif.par_char = data_r;
  assign lif.clk_p = clk_p_r;
  assign lif.clk_n = clk_n_r;
  assign lif.st_flag = flag_r;
  assign lif.pd_flag = powered_down;
  assign lif.reclk = reclk_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clock_pair: assert property (clk_n_r == ~clk_p_r) else $error("Receive clock pair not complementary.");
  a_full_rise: assert property ((lif.rate_sel == deser_pkg::FULL_RATE) && char_tick && !selftest_on |=>
    clk_p_r && (data_r == $past(lif.char_in))) else $error("Full rate data not on rising edge.");
  a_half_toggle: assert property ((lif.rate_sel == deser_pkg::HALF_RATE) && char_tick |=> clk_p_r != $past(clk_p_r)) else $error("Half rate clock did not toggle.");
  a_locked_run: assert property (lif.lock && (lif.rate_sel == deser_pkg::FULL_RATE) ##1
    lif.lock && (lif.rate_sel == deser_pkg::FULL_RATE) |=> clk_p_r != $past(clk_p_r)) else $error("Receive clock stopped while locked.");
  a_data_hold: assert property (!char_tick |=> $stable(data_r)) else $error("Character changed between clock edges.");
  a_selftest_bits: assert property (selftest_on && char_tick |=> data_r[1:0] == $past(lif.st_status[1:0])) else $error("Self-test status not on low bits.");
  a_flag_quiet: assert property (!selftest_on && char_tick |=> !flag_r) else $error("Self-test flag set outside report mode.");
  a_reclk_off: assert property (powered_down |=> !reclk_r) else $error("Reclocker clock runs while powered down.");

  c_half_rate: cover property ((lif.rate_sel == deser_pkg::HALF_RATE) && char_tick);
  c_selftest: cover property (selftest_on && char_tick ##1 flag_r);
  c_unlocked: cover property (!lif.lock && half_tick);

endmodule

/* File: deser_rx_out.sv */
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "deser_params.svh"

// Contract
// - Full rate: data changes on true-clock rise.
// - Half rate: data changes on both edges.
// - Receive clock pair toggles continuously at rate.
// - Self-test status on two lowest data bits.
// - Self-test flag valid only for control 10.
// - Powerdown flag high when both enables zero.
// - Training clock paces lane before lock.
// - Locked clock unrelated to training clock.
// - Reclocker clock at character rate, free phase.
// - Reset puts all state at known values.
module deser_rx_out (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Recovered characters and status from the recovery logic on pclk
  input wire logic [3:0][9:0] rx_char_in,
  input wire logic [3:0] rx_lock,
  input wire logic [3:0][2:0] selftest_status_in,
  // Training reference pins
  input wire logic [3:0] training_ref_clock,
  // Parallel output port per channel
  output logic [3:0][9:0] rx_parallel_char,
  output logic [3:0] recovered_char_clock_p,
  output logic [3:0] recovered_char_clock_n,
  output logic [3:0] selftest_state_flag,
  output logic [3:0] reclock_powerdown_flag,
  output logic [3:0] reclock_output_clock,
  // Interrupt
  output logic irq
);

  logic [31:0] ctrl_r;
  logic [31:0] irq_status_r;
  logic [31:0] irq_status_nxt;
  logic [31:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic [31:0] state_word;
  logic [31:0] irq_events;
  logic [3:0] lock_prev_r;
  logic [3:0] flag_prev_r;
  logic [3:0] st_flag_w;
  logic [3:0] pd_flag_w;
  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;

  // Decode: the slave answers with zero wait states; unmapped words read zero and error.
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_hit = (paddr == `OFS_CTRL) || (paddr == `OFS_STATE) ||
                    (paddr == `OFS_IRQ_STATUS) || (paddr == `OFS_IRQ_MASK);
  assign wr_ctrl = access_phase & pwrite & (paddr == `OFS_CTRL);
  assign wr_irq_status = access_phase & pwrite & (paddr == `OFS_IRQ_STATUS);
  assign wr_irq_mask = access_phase & pwrite & (paddr == `OFS_IRQ_MASK);
  assign pready = access_phase;
  assign pslverr = access_phase & ~addr_hit;
  assign prdata = prdata_r;

  // Read data is captured in the setup cycle, so it stands from a flop in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL: prdata_r <= ctrl_r;
        `OFS_STATE: prdata_r <= state_word;
        `OFS_IRQ_STATUS: prdata_r <= irq_status_r;
        `OFS_IRQ_MASK: prdata_r <= irq_mask_r;
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  // Channel configuration latch; a new setting reaches the lanes in the cycle after the write, not at a character edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= `IRQ_MASK_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_r <= pwdata;
    end
  end

  // Edge history for the lock-loss and self-test events.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_prev_r <= 4'h0;
      flag_prev_r <= 4'h0;
    end else begin
      lock_prev_r <= rx_lock;
      flag_prev_r <= st_flag_w;
    end
  end

  // Events: lock lost, and the self-test flag rising.
  always_comb begin
    irq_events = 32'h00000000;
    irq_events[`IRQ_LOCK_LO +: `NUM_CH] = lock_prev_r & ~rx_lock;
    irq_events[`IRQ_ST_LO +: `NUM_CH] = st_flag_w & ~flag_prev_r;
  end

  // Write-one-to-clear; an event in the clearing cycle still sets, so none is lost.
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_irq_status) begin
      irq_status_nxt = irq_status_nxt & ~pwdata;
    end
    irq_status_nxt = irq_status_nxt | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 32'h00000000;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  assign irq = |(irq_status_r & irq_mask_r);

  // Four independent lanes, each with its own settings and pacing.
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch++) begin : g_lane
      lane_if lif();

      assign lif.rate_sel = deser_pkg::rate_t'(ctrl_r[ch * `CH_STRIDE + `CTRL_RATE_BIT]);
      assign lif.st_ctrl = ctrl_r[ch * `CH_STRIDE + `CTRL_ST_LO +: 2];
      assign lif.en_one = ctrl_r[ch * `CH_STRIDE + `CTRL_EN_ONE_BIT];
      assign lif.en_two = ctrl_r[ch * `CH_STRIDE + `CTRL_EN_TWO_BIT];
      assign lif.lock = rx_lock[ch];
      assign lif.char_in = rx_char_in[ch];
      assign lif.st_status = selftest_status_in[ch];

      rx_out_lane u_lane (
        .pclk(pclk),
        .presetn(presetn),
        .training_ref_clock(training_ref_clock[ch]),
        .lif(lif)
      );

      assign rx_parallel_char[ch] = lif.par_char;
      assign recovered_char_clock_p[ch] = lif.clk_p;
      assign recovered_char_clock_n[ch] = lif.clk_n;
      assign st_flag_w[ch] = lif.st_flag;
      assign pd_flag_w[ch] = lif.pd_flag;
      assign reclock_output_clock[ch] = lif.reclk;

      // State word: lock, powerdown and self-test flag of this lane.
      assign state_word[ch * `CH_STRIDE + `STATE_LOCK_BIT] = rx_lock[ch];
      assign state_word[ch * `CH_STRIDE + `STATE_PD_BIT] = lif.pd_flag;
      assign state_word[ch * `CH_STRIDE + `STATE_ST_BIT] = lif.st_flag;
      assign state_word[ch * `CH_STRIDE + `STATE_ST_BIT + 1 +: 5] = 5'h00;
    end
  endgenerate

  assign selftest_state_flag = st_flag_w;
  assign reclock_powerdown_flag = pd_flag_w;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pd_follows_ctrl: assert property (wr_ctrl && pwdata[`CTRL_EN_ONE_BIT] == 1'b0 &&
    pwdata[`CTRL_EN_TWO_BIT] == 1'b0 |=> reclock_powerdown_flag[0]) else $error("Powerdown flag missed.");
  a_w1c_set_wins: assert property (wr_irq_status && irq_events[0] |=> irq_status_r[0]) else $error("Event lost on clear.");
  a_w1c_clear: assert property (wr_irq_status && pwdata[0] && !irq_events[0] |=> !irq_status_r[0]) else $error("Status bit not cleared.");
  a_irq_level: assert property (irq_mask_r[4] && $rose(st_flag_w[0]) |=> ##1 irq) else $error("Unmasked event gave no interrupt.");

  c_lock_loss: cover property ($fell(rx_lock[1]) ##1 irq_status_r[1]);
  c_unmapped: cover property (pslverr);

endmodule

/* File: host_rx_model.sv */
`timescale 1ns/1ps

// Host sink that takes each character after its launching receive clock edge.
module host_rx_model (
  // Clocks
  input wire logic pclk,
  input wire logic clk_p,
  // Mode
  input wire logic half,
  input wire logic st_on,
  // Parallel pins
  input wire deser_pkg::char_t par_char,
  output deser_pkg::char_t got
);
  logic last_p = 1'b0;

  // Sampling half a pclk later keeps clear of the edge that launches data.
  always @(negedge pclk) begin
    last_p <= clk_p;
    if (clk_p !== last_p && (half || clk_p)) begin
      got <= st_on ? {8'h00, par_char[1:0]} : par_char;
    end
  end
endmodule

/* File: deserializer_rx_output_port_bench.sv */
`timescale 1ns/1ps

module deserializer_rx_output_port_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [3:0][9:0] rx_char_in = 40'h0000000000;
  logic [3:0] rx_lock = 4'h0;
  logic [3:0] training_ref_clock = 4'h0;
  logic [3:0][2:0] selftest_status_in = 12'h000;
  logic [3:0][9:0] rx_parallel_char;
  logic [3:0] cp, cn, stf, pdf, rclk;
  logic [3:0] half_r = 4'h0;
  logic [3:0] st_r = 4'h0;
  deser_pkg::char_t host_got [4];
  logic [15:0] seed = 16'h0054;
  logic trg_run = 1'b0;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int t1, t2;

  // Clock at 10 MHz.
  always #50 pclk = ~pclk;

  deser_rx_out u_deser_rx_out (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_char_in(rx_char_in), .rx_lock(rx_lock),
    .selftest_status_in(selftest_status_in), .training_ref_clock(training_ref_clock),
    .rx_parallel_char(rx_parallel_char), .recovered_char_clock_p(cp),
    .recovered_char_clock_n(cn), .selftest_state_flag(stf), .reclock_powerdown_flag(pdf),
    .reclock_output_clock(rclk), .irq(irq));

  // One host per channel, so every lane is observed on its own.
  for (genvar g = 0; g < 4; g++) begin : g_host
    host_rx_model u_host_rx_model (.pclk(pclk), .clk_p(cp[g]), .half(half_r[g]), .st_on(st_r[g]),
      .par_char(rx_parallel_char[g]), .got(host_got[g]));
  end

  // Slow training clock for the unlocked lanes, and the hang guard.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (trg_run && cyc % 4 == 0) begin
      training_ref_clock <= ~training_ref_clock;
    end
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // The pair must stay complementary on every lane at all times.
  always @(negedge pclk) begin
    if (presetn) begin
      check(cn, 4'(~cp));
    end
  end

  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Control word with one lane changed and the rest at their reset byte.
  function automatic logic [31:0] ctrl_w(input int ch, input logic [7:0] b);
    logic [31:0] r;
    r = 32'h18181818;
    r[ch*8 +: 8] = b;
    return r;
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The wait has no cycle limit of its own; the bench's hang guard ends a stuck transfer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts receive clock and reclocker clock toggles of one lane.
  task automatic cnt(input int ch, input int n);
    logic p, r;
    p = cp[ch];
    r = rclk[ch];
    t1 = 0;
    t2 = 0;
    repeat (n) begin
      @(negedge pclk);
      t1 += (cp[ch] !== p);
      t2 += (rclk[ch] !== r);
      p = cp[ch];
      r = rclk[ch];
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(cn, 4'hF);
    check(pdf | rclk | stf, 4'h0);
    apb(1'b0, 12'h000, 32'h00000000);
    check(rd, 32'h18181818);
    apb(1'b0, 12'h00C, 32'h00000000);
    check(rd, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    check({er, rd}, 33'h100000000);
    // Full rate toggles once per pclk when locked, half rate every second.
    rx_lock <= 4'hF;
    for (int ch = 0; ch < 4; ch++) begin
      for (int h = 0; h < 2; h++) begin
        apb(1'b1, 12'h000, ctrl_w(ch, 8'h18 | 8'(h)));
        half_r[ch] <= h[0];
        seed = lf(seed);
        rx_char_in[ch] <= seed[9:0];
        repeat (8) @(posedge pclk);
        cnt(ch, 16);
        check(t1, h ? 8 : 16);
        check(t2, 16);
        check(rx_parallel_char[ch], rx_char_in[ch]);
        check(host_got[ch], rx_char_in[ch]);
      end
    end
    // Unlocked lanes are paced by the training clock only.
    rx_lock <= 4'h0;
    trg_run <= 1'b1;
    apb(1'b1, 12'h000, 32'h18181818);
    repeat (8) @(posedge pclk);
    cnt(0, 64);
    check(t1 >= 15 && t1 <= 17, 1'b1);
    trg_run <= 1'b0;
    repeat (8) @(posedge pclk);
    cnt(0, 16);
    check(t1, 0);
    @(posedge pclk);
    rx_lock <= 4'hF;
    repeat (4) @(posedge pclk);
    cnt(0, 16);
    check(t1, 16);
    // Self-test reporting for every control code on every lane, with only the lane 0 flag event unmasked.
    apb(1'b1, 12'h00C, 32'h00000010);
    apb(1'b1, 12'h008, 32'h000000FF);
    for (int ch = 0; ch < 4; ch++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, 12'h000, ctrl_w(ch, 8'h18 | {5'h00, c[1:0], 1'b0}));
        st_r[ch] <= (c == 2);
        seed = lf(seed);
        selftest_status_in[ch] <= {1'b1, seed[1:0]};
        rx_char_in[ch] <= seed[11:2];
        repeat (8) @(posedge pclk);
        check(stf[ch], c == 2);
        if (c == 2) begin
          check(rx_parallel_char[ch][1:0], selftest_status_in[ch][1:0]);
          check(host_got[ch], {8'h00, selftest_status_in[ch][1:0]});
        end
      end
    end
    apb(1'b0, 12'h008, 32'h00000000);
    check(rd, 32'h000000F0);
    // Lock loss raises a sticky bit; the mask gates the line.
    apb(1'b1, 12'h008, 32'h000000FF);
    rx_lock[2] <= 1'b0;
    apb(1'b0, 12'h008, 32'h00000000);
    check({irq, rd}, 33'h000000004);
    apb(1'b1, 12'h00C, 32'h00000004);
    @(negedge pclk);
    check(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h00000004);
    @(negedge pclk);
    check(irq, 1'b0);
    // Each enable pair, with the flag both on the pin and in STATE.
    for (int ch = 0; ch < 4; ch++) begin
      for (int e = 0; e < 4; e++) begin
        apb(1'b1, 12'h000, ctrl_w(ch, {3'h0, e[1:0], 3'h0}));
        repeat (4) @(posedge pclk);
        check(pdf[ch], e == 0);
        apb(1'b0, 12'h004, 32'h00000000);
        check(rd[ch*8+1], e == 0);
      end
      // The last pair left both outputs on, so power the lane down before counting.
      apb(1'b1, 12'h000, ctrl_w(ch, 8'h00));
      repeat (2) @(posedge pclk);
      cnt(ch, 8);
      check({t2[3:0], rclk[ch]}, 5'h00);
    end
    // A second reset in mid-run restores the configuration.
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check(cn, 4'hF);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h00000000);
    check(rd, 32'h18181818);
    results();
  end
endmodule
